// >>> dv/timer_oc2_tb.sv
`timescale 1ns/10ps
`default_nettype none

module timer_oc2_tb;

	// ****************************************
	// Signals
	// ****************************************
	logic                                 clk;
	logic                                 reset;
	logic                                 ce;
	logic [timer_oc2_pkg::ADDR_W-1:0]     addr;
	logic [timer_oc2_pkg::DATA_W-1:0]     wdata;
	logic                                 wr;
	logic                                 rd;
	logic [timer_oc2_pkg::DATA_W-1:0]     rdata;
	logic                                 stopMode;
	logic                                 waitMode;
	logic                                 waitDisplayTimerOff;
	logic                                 interruptsEnabled;
	logic                                 capturePin;
	logic                                 compareTwoPin;
	logic                                 timerIrq;
	logic                                 waitWake;
	logic [7:0]                           cntA;
	logic [7:0]                           cntB;
	int                                   fails;
	int                                   tests_run;

	timer_oc2 timer_oc2_inst (
		.clk                 (clk),
		.reset               (reset),
		.ce                  (ce),
		.addr                (addr),
		.wdata               (wdata),
		.wr                  (wr),
		.rd                  (rd),
		.rdata               (rdata),
		.stopMode            (stopMode),
		.waitMode            (waitMode),
		.waitDisplayTimerOff (waitDisplayTimerOff),
		.interruptsEnabled   (interruptsEnabled),
		.capturePin          (capturePin),
		.compareTwoPin       (compareTwoPin),
		.timerIrq            (timerIrq),
		.waitWake            (waitWake)
	);

	always #2 clk = ~clk;

	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data appear in the cycle after the strobe and hold until the next read
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		// Back on a rising edge, so callers drive there
		@(posedge clk);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk(name, d & m, exp);
	endtask

	task automatic wait_pin(input logic v);
		int n;
		n = 0;
		@(negedge clk);
		while (compareTwoPin !== v && n < 2000) begin
			@(negedge clk);
			n++;
		end
		if (n == 2000) begin
			fails++;
			$display("[ERR] compareTwoPin expected %b seen %b", v, compareTwoPin);
			give_verdict();
		end
		@(posedge clk);
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Outputs looked at mid-cycle, away from the launching edge
	task automatic look(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		ce = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		stopMode = 1'b1;
		waitMode = 1'b0;
		waitDisplayTimerOff = 1'b0;
		interruptsEnabled = 1'b0;
		capturePin = 1'b1;
		fails = 0;
		tests_run = 0;
		cycles(10);
		reset <= 1'b0;

		// Stop holds the preset count; falling edge arms capture
		look(0);
		chk("pin", {7'h00, compareTwoPin}, 8'h00);
		rd_chk("control", 8'h30, 8'hff, 8'h00);
		rd_chk("countLow", 8'h33, 8'hff, 8'hfc);
		cycles(20);
		rd_chk("countLow", 8'h33, 8'hff, 8'hfc);
		capturePin <= 1'b0;
		cycles(8);
		rd_chk("status", 8'h31, 8'hff, 8'h00);
		stopMode <= 1'b0;
		cycles(2);
		rd_chk("captureFlag", 8'h31, 8'h04, 8'h04);
		rd_chk("captureHigh", 8'h34, 8'hff, 8'hff);
		rd_chk("captureLow", 8'h35, 8'hff, 8'hfc);
		rd_chk("captureFlag", 8'h31, 8'h04, 8'h00);
		$display("test stop_capture done");

		// Storage bytes, then reset in stop with a pending edge
		// Low byte first, so the high write meets a defined low byte
		wr_reg(8'h27, 8'h3c);
		wr_reg(8'h26, 8'ha5);
		rd_chk("cmpHigh", 8'h26, 8'hff, 8'ha5);
		rd_chk("cmpLow", 8'h27, 8'hff, 8'h3c);
		wr_reg(8'h26, 8'h5a);
		rd_chk("cmpLow", 8'h27, 8'hff, 8'h3c);
		stopMode <= 1'b1;
		cycles(2);
		capturePin <= 1'b1;
		cycles(3);
		capturePin <= 1'b0;
		cycles(3);
		reset <= 1'b1;
		cycles(10);
		reset <= 1'b0;
		cycles(1);
		stopMode <= 1'b0;
		cycles(2);
		rd_chk("captureFlag", 8'h31, 8'h04, 8'h00);
		rd_chk("captureLow", 8'h35, 8'hff, 8'hfc);
		rd_chk("cmpHigh", 8'h26, 8'hff, 8'h5a);
		rd_chk("cmpLow", 8'h27, 8'hff, 8'h3c);
		$display("test storage_reset done");

		// Counter restarts at fffc, so 0x0040 is well ahead
		wr_reg(8'h30, 8'h07);
		wr_reg(8'h26, 8'h00);
		rd_reg(8'h31, cntA);
		wr_reg(8'h27, 8'h40);
		wait_pin(1'b1);
		look(1);
		chk("irq", {7'h00, timerIrq}, 8'h01);
		rd_chk("flags", 8'h31, 8'h03, 8'h03);
		// A few counts past the match, well short of 0x0050
		rd_chk("countLow", 8'h33, 8'hf0, 8'h40);
		rd_chk("ovfFlag", 8'h31, 8'h02, 8'h00);
		wr_reg(8'h30, 8'h06);
		wr_reg(8'h27, 8'h60);
		rd_chk("cmpFlag", 8'h31, 8'h01, 8'h00);
		wait_pin(1'b0);
		$display("test compare done");

		// Wait mode wake and freeze
		waitMode <= 1'b1;
		look(3);
		chk("wake", {7'h00, waitWake}, 8'h00);
		@(posedge clk);
		interruptsEnabled <= 1'b1;
		look(3);
		chk("wake", {7'h00, waitWake}, 8'h01);
		@(posedge clk);
		waitDisplayTimerOff <= 1'b1;
		cycles(2);
		rd_reg(8'h33, cntA);
		cycles(20);
		rd_reg(8'h33, cntB);
		chk("frozen", cntB, cntA);
		waitDisplayTimerOff <= 1'b0;
		cycles(12);
		rd_reg(8'h33, cntB);
		chk("running", {7'h00, cntB !== cntA}, 8'h01);
		waitMode <= 1'b0;
		interruptsEnabled <= 1'b0;
		$display("test wait done");

		// Flag still set, but its enable off: no request
		wr_reg(8'h30, 8'h03);
		look(1);
		chk("irqGate", {7'h00, timerIrq}, 8'h00);
		// Level follows a match while the flag is still set
		wr_reg(8'h30, 8'h07);
		wr_reg(8'h27, 8'h80);
		wait_pin(1'b1);
		rd_chk("cmpFlag", 8'h31, 8'h01, 8'h01);
		// High write alone blocks the match at 0x00a0
		wr_reg(8'h30, 8'h06);
		wr_reg(8'h27, 8'ha0);
		wr_reg(8'h26, 8'h00);
		cycles(200);
		look(0);
		chk("inhibit", {7'h00, compareTwoPin}, 8'h01);
		wr_reg(8'h27, 8'hc0);
		wait_pin(1'b0);
		$display("test inhibit done");

		// Falling capture edge while running, just past 0x00c0
		capturePin <= 1'b1;
		cycles(3);
		capturePin <= 1'b0;
		look(8);
		rd_chk("captureFlag", 8'h31, 8'h04, 8'h04);
		rd_chk("captureHigh", 8'h34, 8'hff, 8'h00);
		rd_chk("captureLow", 8'h35, 8'hf0, 8'hc0);
		$display("test capture done");
		give_verdict();
	end

endmodule

`default_nettype wire

// >>> inc/timer_oc2_pkg.sv
package timer_oc2_pkg;

	// ****************************************
	// Bus geometry
	// ****************************************
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFF_CMP_HIGH = 8'h26;
	localparam logic [7:0] OFF_CMP_LOW  = 8'h27;
	localparam logic [7:0] OFF_CONTROL  = 8'h30;
	localparam logic [7:0] OFF_STATUS   = 8'h31;
	localparam logic [7:0] OFF_CNT_HIGH = 8'h32;
	localparam logic [7:0] OFF_CNT_LOW  = 8'h33;
	localparam logic [7:0] OFF_CAP_HIGH = 8'h34;
	localparam logic [7:0] OFF_CAP_LOW  = 8'h35;

	// ****************************************
	// Control bit positions
	// ****************************************
	localparam int unsigned CTL_LEVEL    = 0;
	localparam int unsigned CTL_PIN_EN   = 1;
	localparam int unsigned CTL_CMP_IE   = 2;
	localparam int unsigned CTL_OVF_IE   = 3;
	localparam int unsigned CTL_CAP_IE   = 4;
	localparam int unsigned CTL_CAP_EDGE = 5;

	// ****************************************
	// Status bit positions
	// ****************************************
	localparam int unsigned STS_CMP = 0;
	localparam int unsigned STS_OVF = 1;
	localparam int unsigned STS_CAP = 2;

	// ****************************************
	// Counter values
	// ****************************************
	localparam logic [15:0] CNT_RESET = 16'hfffc;
	localparam logic [15:0] CNT_WRAP  = 16'h0000;
	localparam logic [15:0] CNT_ONE   = 16'h0001;
	localparam logic [7:0]  RD_ZERO   = 8'h00;
	localparam int unsigned BUS_CLOCKS_PER_TICK = 4;

	// Four timer phases, Gray along the loop
	typedef enum logic [1:0] {
		PHASE_ZERO  = 2'b00,
		PHASE_ONE   = 2'b01,
		PHASE_THREE = 2'b11,
		PHASE_TWO   = 2'b10
	} phase_t;

endpackage

// >>> logic/timer_oc2.sv
`timescale 1ns/10ps
`default_nettype none

module timer_oc2 (
	// Clock, reset, enable
	input  wire logic                                clk,
	input  wire logic                                reset,
	input  wire logic                                ce,
	// Register port
	input  wire logic [timer_oc2_pkg::ADDR_W-1:0]    addr,
	input  wire logic [timer_oc2_pkg::DATA_W-1:0]    wdata,
	input  wire logic                                wr,
	input  wire logic                                rd,
	output logic      [timer_oc2_pkg::DATA_W-1:0]    rdata,
	// Power modes
	input  wire logic                                stopMode,
	input  wire logic                                waitMode,
	input  wire logic                                waitDisplayTimerOff,
	input  wire logic                                interruptsEnabled,
	// Pins and requests
	input  wire logic                                capturePin,
	output logic                                     compareTwoPin,
	output logic                                     timerIrq,
	output logic                                     waitWake
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		timer_oc2_pkg::phase_t phase;
		logic [15:0]           cnt;
		logic                  level;
		logic                  pinEnable;
		logic                  cmpIe;
		logic                  ovfIe;
		logic                  capIe;
		logic                  capEdge;
		logic                  inhibit;
		logic                  cmpFlag;
		logic                  ovfFlag;
		logic                  capFlag;
		logic                  cmpArm;
		logic                  ovfArm;
		logic                  capArm;
		logic                  matchPend;
		logic                  capPend;
		logic                  stopArmed;
		logic [15:0]           stopCapVal;
		logic                  stopPrev;
		logic                  capPrev;
		logic                  pin;
		logic                  irq;
		logic                  wake;
		logic [7:0]            rdata;
	} state_t;

	// Kept apart: these bytes must survive reset untouched
	typedef struct packed {
		logic [7:0] cmpHigh;
		logic [7:0] cmpLow;
		logic [7:0] capHigh;
		logic [7:0] capLow;
	} store_t;

	state_t st_reg;
	state_t st_next;
	store_t sd_reg;
	store_t sd_next;

	logic running;
	logic edgeSeen;
	logic stopExit;

	assign running  = !stopMode && !(waitMode && waitDisplayTimerOff);
	assign stopExit = st_reg.stopPrev && !stopMode;
	assign edgeSeen = st_reg.capEdge ? (capturePin && !st_reg.capPrev)
	                                 : (!capturePin && st_reg.capPrev);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_next = st_reg;
		sd_next = sd_reg;
		st_next.capPrev  = capturePin;
		st_next.stopPrev = stopMode;

		if (running) begin
			case (st_reg.phase)
				timer_oc2_pkg::PHASE_ZERO:  st_next.phase = timer_oc2_pkg::PHASE_ONE;
				timer_oc2_pkg::PHASE_ONE:   st_next.phase = timer_oc2_pkg::PHASE_THREE;
				timer_oc2_pkg::PHASE_THREE: st_next.phase = timer_oc2_pkg::PHASE_TWO;
				default:                    st_next.phase = timer_oc2_pkg::PHASE_ZERO;
			endcase
		end

		// step at end of phase two
		if (running && st_reg.phase == timer_oc2_pkg::PHASE_TWO) begin
			st_next.cnt = 16'(st_reg.cnt + timer_oc2_pkg::CNT_ONE);
		end

		// Register reads: answer next cycle, arm flag clears
		if (rd) begin
			if (addr == timer_oc2_pkg::OFF_CMP_HIGH) begin
				st_next.rdata = sd_reg.cmpHigh;
			end else if (addr == timer_oc2_pkg::OFF_CMP_LOW) begin
				st_next.rdata = sd_reg.cmpLow;
			end else if (addr == timer_oc2_pkg::OFF_CONTROL) begin
				st_next.rdata = {2'b00, st_reg.capEdge, st_reg.capIe, st_reg.ovfIe,
				                 st_reg.cmpIe, st_reg.pinEnable, st_reg.level};
			end else if (addr == timer_oc2_pkg::OFF_STATUS) begin
				st_next.rdata = {5'b00000, st_reg.capFlag, st_reg.ovfFlag, st_reg.cmpFlag};
				st_next.cmpArm = st_reg.cmpFlag;
				st_next.ovfArm = st_reg.ovfFlag;
				st_next.capArm = st_reg.capFlag;
			end else if (addr == timer_oc2_pkg::OFF_CNT_HIGH) begin
				st_next.rdata = st_reg.cnt[15:8];
			end else if (addr == timer_oc2_pkg::OFF_CNT_LOW) begin
				st_next.rdata = st_reg.cnt[7:0];
				// status read then low read clears
				if (st_reg.ovfArm) begin
					st_next.ovfFlag = 1'b0;
					st_next.ovfArm  = 1'b0;
				end
			end else if (addr == timer_oc2_pkg::OFF_CAP_HIGH) begin
				st_next.rdata = sd_reg.capHigh;
			end else if (addr == timer_oc2_pkg::OFF_CAP_LOW) begin
				st_next.rdata = sd_reg.capLow;
				if (st_reg.capArm) begin
					st_next.capFlag = 1'b0;
					st_next.capArm  = 1'b0;
				end
			end else begin
				st_next.rdata = timer_oc2_pkg::RD_ZERO;
			end
		end

		// Register writes
		if (wr) begin
			if (addr == timer_oc2_pkg::OFF_CMP_HIGH) begin
				sd_next.cmpHigh = wdata;
				// hold off compares until low byte
				st_next.inhibit = 1'b1;
			end else if (addr == timer_oc2_pkg::OFF_CMP_LOW) begin
				sd_next.cmpLow = wdata;
				st_next.inhibit = 1'b0;
				if (st_reg.cmpArm) begin
					st_next.cmpFlag = 1'b0;
					st_next.cmpArm  = 1'b0;
				end
			end else if (addr == timer_oc2_pkg::OFF_CONTROL) begin
				st_next.level     = wdata[timer_oc2_pkg::CTL_LEVEL];
				st_next.pinEnable = wdata[timer_oc2_pkg::CTL_PIN_EN];
				st_next.cmpIe     = wdata[timer_oc2_pkg::CTL_CMP_IE];
				st_next.ovfIe     = wdata[timer_oc2_pkg::CTL_OVF_IE];
				st_next.capIe     = wdata[timer_oc2_pkg::CTL_CAP_IE];
				st_next.capEdge   = wdata[timer_oc2_pkg::CTL_CAP_EDGE];
			end
		end

		// compare looked at in phase one only
		if (running && st_reg.phase == timer_oc2_pkg::PHASE_ONE) begin
			st_next.matchPend = !st_reg.inhibit
			                    && st_reg.cnt == {sd_reg.cmpHigh, sd_reg.cmpLow};
		end

		// Capture edges: armed while stopped, pended otherwise
		if (edgeSeen) begin
			if (stopMode) begin
				if (!st_reg.stopArmed) begin
					st_next.stopArmed  = 1'b1;
					st_next.stopCapVal = st_reg.cnt;
				end
			end else begin
				st_next.capPend = 1'b1;
			end
		end

		// flag and data show up on wake
		if (stopExit && st_reg.stopArmed) begin
			st_next.stopArmed = 1'b0;
			st_next.capFlag   = 1'b1;
			st_next.capArm    = 1'b0;
			sd_next.capHigh   = st_reg.stopCapVal[15:8];
			sd_next.capLow    = st_reg.stopCapVal[7:0];
		end

		// Flag setting in phase three; set beats clear
		if (running && st_reg.phase == timer_oc2_pkg::PHASE_THREE) begin
			if (st_reg.matchPend) begin
				st_next.cmpFlag   = 1'b1;
				st_next.cmpArm    = 1'b0;
				st_next.matchPend = 1'b0;
				if (st_reg.pinEnable) begin
					st_next.pin = st_reg.level;
				end
			end
			if (st_reg.cnt == timer_oc2_pkg::CNT_WRAP) begin
				st_next.ovfFlag = 1'b1;
				st_next.ovfArm  = 1'b0;
			end
			if (st_reg.capPend && !(edgeSeen && !stopMode)) begin
				st_next.capPend = 1'b0;
				st_next.capFlag = 1'b1;
				st_next.capArm  = 1'b0;
				sd_next.capHigh = st_reg.cnt[15:8];
				sd_next.capLow  = st_reg.cnt[7:0];
			end
		end

		st_next.irq = (st_next.cmpFlag && st_next.cmpIe)
		              || (st_next.ovfFlag && st_next.ovfIe)
		              || (st_next.capFlag && st_next.capIe);
		// wake from wait on an enabled request
		st_next.wake = st_next.irq && waitMode && interruptsEnabled;
	end

	// ****************************************
	// Registers
	// ****************************************
	// reset presets counter, drops arming
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_reg            <= '0;
			st_reg.phase      <= timer_oc2_pkg::PHASE_ZERO;
			st_reg.cnt        <= timer_oc2_pkg::CNT_RESET;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	// no reset and no hardware write on compare bytes
	always_ff @(posedge clk) begin
		if (ce) begin
			sd_reg <= sd_next;
		end
	end

	assign rdata         = st_reg.rdata;
	assign compareTwoPin = st_reg.pin;
	assign timerIrq      = st_reg.irq;
	assign waitWake      = st_reg.wake;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset || !ce);

	logic inPhaseOne;
	logic inPhaseTwo;
	logic inPhaseThree;
	assign inPhaseOne   = running && st_reg.phase == timer_oc2_pkg::PHASE_ONE;
	assign inPhaseTwo   = running && st_reg.phase == timer_oc2_pkg::PHASE_TWO;
	assign inPhaseThree = running && st_reg.phase == timer_oc2_pkg::PHASE_THREE;

	chk_count_step: assert property (inPhaseTwo |=> st_reg.cnt == 16'($past(st_reg.cnt) + 16'h0001))
		else $error("counter did not step after phase two");

	chk_stop_hold: assert property (stopMode ##1 stopMode |-> $stable(st_reg.cnt))
		else $error("counter moved while stopped");

	chk_match_flag: assert property ((inPhaseOne && !st_reg.inhibit
		&& st_reg.cnt == {sd_reg.cmpHigh, sd_reg.cmpLow} && running) ##1 running
		|=> st_reg.cmpFlag)
		else $error("compare flag not set after match");

	chk_inhibit_block: assert property ((inPhaseOne && st_reg.inhibit) |=> !st_reg.matchPend)
		else $error("compare matched while inhibited");

	chk_low_release: assert property ((wr && addr == timer_oc2_pkg::OFF_CMP_LOW) |=> !st_reg.inhibit)
		else $error("low byte write left compare inhibited");

	chk_byte_keep: assert property ((wr && addr == timer_oc2_pkg::OFF_CMP_HIGH)
		|=> sd_reg.cmpHigh == $past(wdata) && $stable(sd_reg.cmpLow))
		else $error("high byte write disturbed low byte");

	chk_pin_drive: assert property ((inPhaseThree && st_reg.matchPend && st_reg.pinEnable)
		|=> compareTwoPin == $past(st_reg.level))
		else $error("compare pin missed output level");

	chk_irq_gate: assert property ((!st_reg.cmpIe && !st_reg.ovfIe && !st_reg.capIe) [*2]
		|-> !timerIrq)
		else $error("interrupt raised with all enables off");

	chk_ovf_set: assert property ((inPhaseThree && st_reg.cnt == 16'h0000) |=> st_reg.ovfFlag)
		else $error("overflow flag missing after wrap");

	chk_wait_wake: assert property ((timerIrq && waitMode && interruptsEnabled) ##1
		(timerIrq && waitMode && interruptsEnabled) |-> waitWake)
		else $error("wait not ended by enabled interrupt");

	chk_stop_capture: assert property ((stopExit && st_reg.stopArmed) |=> st_reg.capFlag)
		else $error("stop-time capture not flagged on wake");

	cov_match: cover property (inPhaseThree && st_reg.matchPend && st_reg.pinEnable);
	cov_overflow: cover property (inPhaseThree && st_reg.cnt == 16'h0000);
	cov_stop_cap: cover property (stopExit && st_reg.stopArmed);
	cov_inhibit: cover property (inPhaseOne && st_reg.inhibit);

endmodule

`default_nettype wire
